// File: src/sbsi_core.v
// Purpose: synchronous burst memory device, control and storage
// Assumes: far side is logic on mclk; output enable, sleep and order select are async
// Notes: read data is registered on the same edge that performs the access
`timescale 1ns/1ps
`default_nettype none
`include "sbsi_regs.vh"

module sbsi_core #(
    parameter LANES     = `SBSI_DEF_LANES,
    parameter ADDR_BITS = `SBSI_DEF_ADDR_BITS
) (
    // clock and reset
    input  wire                          mclk,
    input  wire                          sys_rst,
    // address
    input  wire [ADDR_BITS-1:0]          address,
    input  wire [`SBSI_BURST_BITS-1:0]   burst_low_address,
    // strobes and enables
    input  wire                          processor_addr_strobe_n,
    input  wire                          controller_addr_strobe_n,
    input  wire                          burst_advance_n,
    input  wire                          chip_enable_n,
    input  wire                          second_chip_enable_n,
    input  wire                          second_chip_enable,
    // write controls
    input  wire                          global_write_n,
    input  wire                          byte_write_gate_n,
    input  wire [LANES-1:0]              lane_write_enable_n,
    // asynchronous controls
    input  wire                          output_enable_n,
    input  wire                          sleep_request,
    input  wire                          burst_order,
    // data and parity pins, split
    input  wire [LANES*`SBSI_LANE_BITS-1:0] data_lanes_in,
    input  wire [LANES-1:0]              parity_lanes_in,
    output reg  [LANES*`SBSI_LANE_BITS-1:0] data_lanes_out,
    output reg  [LANES-1:0]              parity_lanes_out,
    output reg                           lanes_oe_n
);
    localparam WORD_BITS = LANES * `SBSI_LANE_WIDTH;
    localparam MEM_BITS  = ADDR_BITS + `SBSI_BURST_BITS;
    localparam DEPTH     = 1 << MEM_BITS;

    // async pins: oe, sleep, order; bit 0 oe, 1 sleep, 2 order
    reg  [2:0] sync_a;
    reg  [2:0] sync_b;
    wire       oe_n_s  = sync_b[0];
    wire       sleep_s = sync_b[1];
    wire       order_s = sync_b[2];

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= `SBSI_SYNC_RST;
            sync_b <= `SBSI_SYNC_RST;
        end else begin
            sync_a <= {burst_order, sleep_request, output_enable_n};
            sync_b <= sync_a;
        end
    end

    // storage: word is lane-ordered, each lane parity above its eight bits
    reg  [WORD_BITS-1:0] mem [0:DEPTH-1];
    reg  [ADDR_BITS-1:0] hi_addr;
    reg                  active;

    wire [`SBSI_BURST_BITS-1:0] cur_low;
    wire [`SBSI_BURST_BITS-1:0] nxt_low;

    // decode of the current edge
    wire selected = ~chip_enable_n & ~second_chip_enable_n & second_chip_enable;
    wire any_lane = ~(&lane_write_enable_n);
    wire wr_cond  = ~global_write_n | (~byte_write_gate_n & any_lane);

    reg  do_load;
    reg  do_deselect;
    reg  do_step;
    reg  do_access;
    reg  is_write;

    always @* begin
        do_load     = 1'b0;
        do_deselect = 1'b0;
        do_step     = 1'b0;
        do_access   = 1'b0;
        is_write    = 1'b0;
        if (sleep_s) begin
            do_access = 1'b0;
        end else if (~processor_addr_strobe_n & ~chip_enable_n) begin
            // write controls are ignored on this edge
            if (selected) begin
                do_load   = 1'b1;
                do_access = 1'b1;
            end else begin
                do_deselect = 1'b1;
            end
        end else if (~controller_addr_strobe_n) begin
            if (selected) begin
                do_load   = 1'b1;
                do_access = 1'b1;
                is_write  = wr_cond;
            end else begin
                do_deselect = 1'b1;
            end
        end else if (active) begin
            // enables not examined mid-burst; write here follows
            do_access = 1'b1;
            do_step   = ~burst_advance_n;
            is_write  = wr_cond;
        end
    end

    sbsi_burst_seq u_seq (
        .mclk             (mclk),
        .sys_rst          (sys_rst),
        .load             (do_load),
        .step             (do_step),
        .order_interleave (order_s == `SBSI_ORDER_INTERLV),
        .start_low        (burst_low_address),
        .cur_low          (cur_low),
        .next_low         (nxt_low)
    );

    wire [MEM_BITS-1:0] acc_addr = do_load ? {address, burst_low_address}
                                 : {hi_addr, (do_step ? nxt_low : cur_low)};

    // lane write mask
    wire [LANES-1:0] lane_en = ~global_write_n ? {LANES{1'b1}}
                             : (~byte_write_gate_n ? ~lane_write_enable_n
                                                   : {LANES{1'b0}});

    wire [WORD_BITS-1:0] old_word = mem[acc_addr];
    wire [WORD_BITS-1:0] new_word;
    wire [WORD_BITS-1:0] merged;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            assign new_word[g*`SBSI_LANE_WIDTH +: `SBSI_LANE_WIDTH] =
                {parity_lanes_in[g], data_lanes_in[g*`SBSI_LANE_BITS +: `SBSI_LANE_BITS]};
            sbsi_lane_merge u_merge (
                .old_lane    (old_word[g*`SBSI_LANE_WIDTH +: `SBSI_LANE_WIDTH]),
                .new_lane    (new_word[g*`SBSI_LANE_WIDTH +: `SBSI_LANE_WIDTH]),
                .write_en    (lane_en[g]),
                .merged_lane (merged[g*`SBSI_LANE_WIDTH +: `SBSI_LANE_WIDTH])
            );
        end
    endgenerate

    // memory has no reset; contents are undefined until written
    always @(posedge mclk) begin
        if (do_access & is_write) begin
            mem[acc_addr] <= merged;
        end
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_addr <= {ADDR_BITS{1'b0}};
            active  <= 1'b0;
        end else if (do_load) begin
            hi_addr <= address;
            active  <= 1'b1;
        end else if (do_deselect) begin
            active  <= 1'b0;
        end
    end

    // read path; drive only on reads with oe low, and never in sleep
    integer k;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            data_lanes_out   <= {LANES*`SBSI_LANE_BITS{1'b0}};
            parity_lanes_out <= {LANES{1'b0}};
            lanes_oe_n       <= `SBSI_OE_N_RST;
        end else begin
            lanes_oe_n <= ~(do_access & ~is_write & ~oe_n_s);
            if (do_access & ~is_write) begin
                for (k = 0; k < LANES; k = k + 1) begin
                    data_lanes_out[k*`SBSI_LANE_BITS +: `SBSI_LANE_BITS] <=
                        old_word[k*`SBSI_LANE_WIDTH +: `SBSI_LANE_BITS];
                    parity_lanes_out[k] <=
                        old_word[k*`SBSI_LANE_WIDTH + `SBSI_LANE_BITS];
                end
            end
        end
    end
endmodule // sbsi_core

`default_nettype wire

// File: src/sbsi_regs.vh
// Purpose: constants shared by the synchronous burst memory interface
// Assumes: one clock, mclk at 200 MHz, async active-high reset
// Notes: Operation list below, one line per behaviour
//
// Operation
// - new access only with all three enables true; else strobe deselects (processor strobe only with first enable low), bus floats
// - selected, processor strobe low: load address, begin read, ignore other controls
// - controller strobe alone: load address, burst is write or read per write condition
// - no strobes, advance low: step burst address, read or write, enables ignored
// - no strobes, advance high: hold address and repeat access as wait state
// - write when global write low, or gate and any lane enable low
// - each lane enable writes only its own data lane and parity bit
// - lane count follows organisation: two, four or eight lanes
// - parity bit stored and returned alongside its own lane's eight bits
// - address, strobe, enable, write and data inputs sampled on rising edge only
// - sleep high forces power-down and floating data whatever else happens
// - data outputs float from power-up until an access drives them
// - static order select picks the burst sequence for every burst
// - order select high: start, then start xor 01, 10, 11
// - captured low address bits set the burst start; load clears the two-bit beat counter to zero
`ifndef SBSI_REGS_VH
`define SBSI_REGS_VH

`define SBSI_LANE_BITS      8
`define SBSI_LANE_WIDTH     9
`define SBSI_BURST_BITS     2
`define SBSI_DEF_LANES      4
`define SBSI_DEF_ADDR_BITS  10
`define SBSI_ORDER_INTERLV  1'b1
`define SBSI_SYNC_RST       3'h0
`define SBSI_OE_N_RST       1'b1
`define SBSI_BEAT_RST       2'h0
`define SBSI_BEAT_STEP      2'h1

`endif

// File: src/sbsi_lane_merge.v
// Purpose: merge one lane of write data into a stored word
// Assumes: lane is eight data bits plus one parity bit
// Notes: enable high takes the new lane, low keeps the old one
`timescale 1ns/1ps
`default_nettype none
`include "sbsi_regs.vh"

module sbsi_lane_merge (
    // lane values
    input  wire [`SBSI_LANE_WIDTH-1:0] old_lane,
    input  wire [`SBSI_LANE_WIDTH-1:0] new_lane,
    // control
    input  wire                        write_en,
    // result
    output wire [`SBSI_LANE_WIDTH-1:0] merged_lane
);
    assign merged_lane = write_en ? new_lane : old_lane;
endmodule // sbsi_lane_merge

`default_nettype wire

// File: src/sbsi_burst_seq.v
// Purpose: two-bit burst counter with interleaved or linear order
// Assumes: load and step are never asked for in the same cycle
// Notes: next_low is the low address of the beat after the current one
`timescale 1ns/1ps
`default_nettype none
`include "sbsi_regs.vh"

module sbsi_burst_seq (
    // clock and reset
    input  wire                        mclk,
    input  wire                        sys_rst,
    // control
    input  wire                        load,
    input  wire                        step,
    input  wire                        order_interleave,
    input  wire [`SBSI_BURST_BITS-1:0] start_low,
    // addresses
    output wire [`SBSI_BURST_BITS-1:0] cur_low,
    output wire [`SBSI_BURST_BITS-1:0] next_low
);
    reg  [`SBSI_BURST_BITS-1:0] start;
    reg  [`SBSI_BURST_BITS-1:0] beat;
    wire [`SBSI_BURST_BITS-1:0] beat_after;

    assign beat_after = beat + `SBSI_BEAT_STEP;

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            start <= `SBSI_BEAT_RST;
            beat  <= `SBSI_BEAT_RST;
        end else if (load) begin
            start <= start_low;
            beat  <= `SBSI_BEAT_RST;
        end else if (step) begin
            beat  <= beat_after;
        end
    end

    // order is re-read every beat, so it must stay static during a burst
    assign cur_low  = order_interleave ? (start ^ beat) : (start + beat);
    assign next_low = order_interleave ? (start ^ beat_after)
                                       : (start + beat_after);
endmodule // sbsi_burst_seq

`default_nettype wire

// File: bench/sbsi_core_chk.sv
// Purpose: port-level properties of the burst memory device
// Assumes: one clock, async active-high reset
// Notes: async controls take three edges to settle
`timescale 1ns/1ps
`default_nettype none
module sbsi_core_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // controls
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic chip_enable_n,
    input wire logic second_chip_enable_n,
    input wire logic second_chip_enable,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // result
    input wire logic lanes_oe_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic sel = !chip_enable_n && !second_chip_enable_n && second_chip_enable;
    // processor strobe only counts with the first enable low
    wire logic pst = !processor_addr_strobe_n && !chip_enable_n;
    wire logic cst = !pst && !controller_addr_strobe_n;
    wire logic cont = !pst && controller_addr_strobe_n;
    sequence s_quiet;
        (!sleep_request && !output_enable_n) [*3];
    endsequence
    sequence s_desel;
        (pst || cst) && !sel ##1 cont;
    endsequence
    a_reset_float: assert property ($fell(sys_rst) |-> lanes_oe_n [*2])
        else $error("data driven after reset");
    a_sleep_float: assert property (sleep_request [*3] |=> lanes_oe_n)
        else $error("data driven in sleep");
    a_oe_float: assert property (output_enable_n [*3] |=> lanes_oe_n)
        else $error("data driven with oe high");
    a_proc_read: assert property (s_quiet ##0 (pst && sel) |=> !lanes_oe_n)
        else $error("processor read not driven");
    a_ctrl_read: assert property (s_quiet ##0 (cst && sel && global_write_n
        && byte_write_gate_n) |=> !lanes_oe_n)
        else $error("controller read not driven");
    a_ctrl_write: assert property (cst && sel && !global_write_n |=> lanes_oe_n)
        else $error("write drove data");
    a_desel_idle: assert property (s_desel |-> lanes_oe_n ##1 lanes_oe_n)
        else $error("deselected device drove data");
    a_cont_write: assert property (cont && !global_write_n |=> lanes_oe_n)
        else $error("burst write drove data");
endmodule // sbsi_core_chk
`default_nettype wire

// File: bench/sbsi_host.sv
// Purpose: processor-side model driving the burst memory pins
// Assumes: pins change 1 ns after the rising edge of mclk
// Notes: released data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sbsi_host (
    // clock
    input  wire logic        mclk,
    // pins toward the device
    output var  logic [11:0] ctl,
    output var  logic [9:0]  address,
    output var  logic [1:0]  burst_low_address,
    output var  logic [35:0] wdata
);
    initial begin
        ctl = 12'he7f;
        {address, burst_low_address} = 12'h000;
        wdata = 36'h0;
    end
    // ctl: strobes, advance, three enables, global write, gate, lanes
    task automatic cyc(input logic [11:0] c, input logic [11:0] wa, input logic [35:0] d);
        @(posedge mclk);
        #1;
        ctl <= c;
        {address, burst_low_address} <= wa;
        wdata <= (!c[5] || (!c[4] && c[3:0] != 4'hf)) ? d : ~wdata;
    endtask
endmodule // sbsi_host
`default_nettype wire

// File: bench/sync_burst_sram_interface_test.sv
// Purpose: self-checking bench for the burst memory device
// Assumes: four lanes, ten upper address bits, mclk at 200 MHz
// Notes: read data shows right after the edge that takes it
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_interface_test;
    localparam logic [11:0] c_idle = 12'he7f, c_advr = 12'hc7f, c_advw = 12'hc5f;
    localparam logic [11:0] c_prd = 12'h67f, c_prw = 12'h65f, c_crd = 12'ha7f;
    localparam logic [11:0] c_cwr = 12'ha5f, c_cbw = 12'ha6d, c_cds = 12'ha3f;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        output_enable_n = 1'b0;
    logic        sleep_request = 1'b0;
    logic        burst_order = 1'b1;
    logic [11:0] ctl;
    logic [9:0]  address;
    logic [1:0]  burst_low_address;
    logic [35:0] wdata;
    logic [31:0] data_lanes_out;
    logic [3:0]  parity_lanes_out;
    logic        lanes_oe_n;
    logic [35:0] m [0:4095];
    int          err_count = 0;
    int          checks = 0;
    always #2.5 mclk = ~mclk;
    sbsi_host sbsi_host_inst (.mclk(mclk), .ctl(ctl), .address(address),
        .burst_low_address(burst_low_address), .wdata(wdata));
    sbsi_core #(.LANES(4), .ADDR_BITS(10)) sbsi_core_inst (.mclk(mclk), .sys_rst(sys_rst),
        .address(address), .burst_low_address(burst_low_address),
        .processor_addr_strobe_n(ctl[11]), .controller_addr_strobe_n(ctl[10]),
        .burst_advance_n(ctl[9]), .chip_enable_n(ctl[8]), .second_chip_enable_n(ctl[7]),
        .second_chip_enable(ctl[6]), .global_write_n(ctl[5]), .byte_write_gate_n(ctl[4]),
        .lane_write_enable_n(ctl[3:0]), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .burst_order(burst_order),
        .data_lanes_in(wdata[31:0]), .parity_lanes_in(wdata[35:32]),
        .data_lanes_out(data_lanes_out), .parity_lanes_out(parity_lanes_out),
        .lanes_oe_n(lanes_oe_n));
    task automatic op(input logic [11:0] c, input logic [11:0] wa, input logic [35:0] d);
        sbsi_host_inst.cyc(c, wa, d);
    endtask
    task automatic idle(input int n);
        repeat (n) op(c_idle, 12'h000, 36'h0);
    endtask
    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    function automatic logic [35:0] pat(input logic [11:0] w);
        return {w, ~w, w};
    endfunction
    // one access, then a suspend cycle to expose its data
    task automatic rd1(input logic [11:0] c, input logic [11:0] wa);
        op(c, wa, 36'h0);
        idle(1);
        chk({parity_lanes_out, data_lanes_out}, m[wa]);
    endtask
    task automatic rdb(input logic [11:0] c, input logic [11:0] wa, input logic [7:0] ord);
        op(c, wa, 36'h0);
        for (int i = 0; i < 4; i++) begin
            op(c_advr, 12'h000, 36'h0);
            chk(36'(lanes_oe_n), 36'h0);
            chk({parity_lanes_out, data_lanes_out}, m[{wa[11:2], ord[2*i+:2]}]);
        end
    endtask
    task automatic t_fill;
        op(c_cwr, 12'h010, pat(12'h010));
        m[12'h010] = pat(12'h010);
        for (int i = 1; i < 4; i++) begin
            op(c_advw, 12'h000, pat(12'h010 + 12'(i)));
            m[12'h010 + 12'(i)] = pat(12'h010 + 12'(i));
        end
        rdb(c_prd, 12'h012, 8'h4e);
        idle(2);
        chk({parity_lanes_out, data_lanes_out}, m[12'h012]);
    endtask
    task automatic t_bytes;
        op(c_prw, 12'h020, 36'h1_2345_6789);
        // raise oe; it passes the two-stage sync, so the read edge still drives data
        output_enable_n = 1'b1;
        op(c_advw, 12'h000, pat(12'h021));
        chk(36'(lanes_oe_n), 36'h0);
        m[12'h021] = pat(12'h021);
        op(c_cbw, 12'h011, 36'hf_ffff_ffff);
        m[12'h011] = m[12'h011] | 36'h2_0000_ff00;
        output_enable_n = 1'b0;
        rd1(c_prd, 12'h021);
        rd1(c_crd, 12'h011);
    endtask
    task automatic t_modes;
        burst_order = 1'b0;
        idle(3);
        rdb(c_crd, 12'h013, 8'h93);
        burst_order = 1'b1;
        op(c_cds, 12'h010, 36'h0);
        op(c_advr, 12'h000, 36'h0);
        chk(36'(lanes_oe_n), 36'h1);
        idle(1);
        chk(36'(lanes_oe_n), 36'h1);
    endtask
    task automatic t_float;
        output_enable_n = 1'b1;
        idle(3);
        op(c_prd, 12'h010, 36'h0);
        idle(1);
        chk(36'(lanes_oe_n), 36'h1);
        output_enable_n = 1'b0;
        sleep_request = 1'b1;
        idle(3);
        op(c_cwr, 12'h010, 36'h0);
        op(c_prd, 12'h010, 36'h0);
        idle(1);
        chk(36'(lanes_oe_n), 36'h1);
        sleep_request = 1'b0;
        idle(3);
        rd1(c_prd, 12'h010);
    endtask
    task automatic summarize;
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        idle(1);
        chk(36'(lanes_oe_n), 36'h1);
        t_fill;
        t_bytes;
        t_modes;
        t_float;
        summarize;
    end
endmodule // sync_burst_sram_interface_test
bind sbsi_core sbsi_core_chk sbsi_core_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .chip_enable_n(chip_enable_n),
    .second_chip_enable_n(second_chip_enable_n), .second_chip_enable(second_chip_enable),
    .global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .lanes_oe_n(lanes_oe_n));
`default_nettype wire
